//--- shared/boot_entry_pkg.sv
// constants and helpers shared by the boot mode entry logic
package boot_entry_pkg;

	// ***********************************************
	// register offsets (byte addresses)
	// ***********************************************
	localparam logic [3:0] ADDR_STATUS  = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_BAUD    = 4'h8;
	localparam logic [3:0] ADDR_MODE    = 4'hC;

	// ***********************************************
	// field positions
	// ***********************************************
	localparam int ST_BOOT     = 0;
	localparam int ST_USER     = 1;
	localparam int ST_ALIGNED  = 2;
	localparam int ST_ERASED   = 3;
	localparam int ST_HANDOFF  = 4;
	localparam int ST_PE_BLOCK = 5;
	localparam int ST_LOADING  = 6;
	localparam int CT_LOAD_DONE = 0;
	localparam int CT_RX_EN     = 1;
	localparam int CT_TX_EN     = 2;

	// ***********************************************
	// reset values and codes
	// ***********************************************
	localparam logic [15:0] BAUD_RESET   = 16'h0000;
	localparam logic [15:0] RAM_ENTRY    = 16'hFBE0;
	localparam logic [7:0]  BLANK_BYTE   = 8'hFF;
	localparam logic [7:0]  ALIGN_ACK    = 8'h00;
	localparam logic [7:0]  HOST_ACK     = 8'h55;
	localparam logic [1:0]  MODE1        = 2'h1;
	localparam logic [1:0]  MODE2        = 2'h2;
	localparam logic [1:0]  MODE3        = 2'h3;

	// ***********************************************
	// timing counts
	// ***********************************************
	// 100 states from reset release until the low period can be timed
	localparam logic [7:0]  READY_STATES = 8'h64;
	// start bit plus eight zero data bits
	localparam logic [15:0] LOW_BITS     = 16'h0009;

	// bit period minus one, never below zero
	function automatic logic [15:0] bit_len_m1(input logic [15:0] bits);
		bit_len_m1 = (bits == 16'h0000) ? 16'h0000 : bits - 16'h0001;
	endfunction

endpackage

//--- verilog/rate_meter.sv
// low period timer that derives the host bit period
`timescale 1ns/10ps
module rate_meter
	import boot_entry_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// control
	input  wire logic        i_arm,
	input  wire logic        i_rx,
	// result
	output logic      [15:0] o_bit_cycles,
	output logic             o_done
);

	typedef enum logic [2:0] {M_OFF, M_WARM, M_HIGH, M_LOW, M_HOLD} meter_e;

	meter_e      state;
	meter_e      next_state;
	logic [7:0]  warm;
	logic [7:0]  next_warm;
	logic [15:0] low_cnt;
	logic [15:0] next_low_cnt;
	logic [15:0] next_bit_cycles;
	logic        next_done;

	always_comb begin
		next_state      = state;
		next_warm       = warm;
		next_low_cnt    = low_cnt;
		next_bit_cycles = o_bit_cycles;
		next_done       = 1'b0;
		case (state)
			M_OFF: begin
				next_warm = 8'h00;
				if (i_arm) begin
					next_state = M_WARM;
				end
			end
			M_WARM: begin
				if (warm != READY_STATES - 8'h01) begin
					next_warm = warm + 8'h01; // (R3)
				end else if (i_rx) begin
					next_state = M_HIGH;
				end
			end
			M_HIGH: begin
				next_low_cnt = 16'h0000;
				if (!i_rx) begin
					next_state = M_LOW; // (R1)
				end
			end
			M_LOW: begin
				if (!i_rx) begin
					if (low_cnt != 16'hFFFF) begin
						next_low_cnt = low_cnt + 16'h0001;
					end
				end else begin
					next_bit_cycles = (low_cnt + 16'h0001) / LOW_BITS; // (R1)
					next_done       = 1'b1;
					next_state      = M_HOLD;
				end
			end
			M_HOLD: begin
				next_state = M_HOLD;
			end
			default: begin
				next_state = M_OFF;
			end
		endcase
		if (!i_arm) begin
			next_state = M_OFF;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state        <= M_OFF;
			warm         <= 8'h00;
			low_cnt      <= 16'h0000;
			o_bit_cycles <= BAUD_RESET;
			o_done       <= 1'b0;
		end else begin
			state        <= next_state;
			warm         <= next_warm;
			low_cnt      <= next_low_cnt;
			o_bit_cycles <= next_bit_cycles;
			o_done       <= next_done;
		end
	end

endmodule

//--- verilog/serial_byte_tx.sv
// one byte asynchronous transmitter, eight data bits and one stop bit
`timescale 1ns/10ps
module serial_byte_tx
	import boot_entry_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// request
	input  wire logic        i_start,
	input  wire logic [7:0]  i_data,
	input  wire logic [15:0] i_bit_cycles,
	// line and status
	output logic             o_tx,
	output logic             o_busy,
	output logic             o_done
);

	logic [9:0]  shreg;
	logic [9:0]  next_shreg;
	logic [3:0]  bitn;
	logic [3:0]  next_bitn;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [15:0] per;
	logic [15:0] next_per;
	logic        next_busy;
	logic        next_tx;
	logic        next_done;

	always_comb begin
		next_shreg = shreg;
		next_bitn  = bitn;
		next_cnt   = cnt;
		next_per   = per;
		next_busy  = o_busy;
		next_tx    = 1'b1;
		next_done  = 1'b0;
		if (!o_busy) begin
			if (i_start) begin
				next_busy  = 1'b1;
				next_shreg = {1'b1, i_data, 1'b0};
				next_bitn  = 4'h0;
				next_cnt   = 16'h0000;
				next_per   = bit_len_m1(i_bit_cycles);
			end
		end else begin
			next_tx = shreg[0];
			if (cnt == per) begin
				next_cnt   = 16'h0000;
				next_shreg = {1'b1, shreg[9:1]};
				next_bitn  = bitn + 4'h1;
				if (bitn == 4'h9) begin
					next_busy = 1'b0;
					next_done = 1'b1;
					next_tx   = 1'b1;
				end
			end else begin
				next_cnt = cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shreg  <= 10'h3FF;
			bitn   <= 4'h0;
			cnt    <= 16'h0000;
			per    <= 16'h0000;
			o_busy <= 1'b0;
			o_tx   <= 1'b1;
			o_done <= 1'b0;
		end else begin
			shreg  <= next_shreg;
			bitn   <= next_bitn;
			cnt    <= next_cnt;
			per    <= next_per;
			o_busy <= next_busy;
			o_tx   <= next_tx;
			o_done <= next_done;
		end
	end

endmodule

//--- verilog/boot_mode_entry_control.sv
// boot mode entry, persistence and hand-off, and user programming mode select
//
// How it works
// (R1) boot start times the low interval on the serial receive line for bit rate
// (R2) host holds the receive line high when reset is released
// (R3) about 100 states pass after reset before low timing begins
// (R4) flash is scanned; any byte not H'FF erases all blocks
// (R5) interrupts are held off while flash is programmed or erased
// (R6) hand-off clears receive and transmit enables, keeps derived bit rate
// (R7) at hand-off transmit pin high, port 8 bit 4 direction and data set
// (R8) downloaded program sets up its own general registers and stack
// (R9) all other registers stay at reset values through hand-off
// (R10) at reset release both high-voltage pins are sampled into boot state
// (R11) host exits boot by reset low ten cycles, drop voltage, release
// (R12) external pin settings stay constant during boot mode
// (R13) losing the boot-pin voltage without reset keeps boot mode
// (R14) watchdog reset keeps boot state and restarts the boot sequence
// (R15) only the external reset pin clears the stored boot state
// (R16) during reset address ports and strobes follow the mode pins
// (R17) user programming mode needs on-chip ROM mode plus supply high voltage
// (R18) user programming mode changes only flash behaviour
// (R19) hardware standby is refused while the supply high voltage is present
// (R20) flash reads are blocked while programming or erasing
// (R21) watchdog should run while programming voltage is applied
// (R22) in boot mode the mode report follows the low mode pin
// (R23) after alignment send H'00, then wait for host H'55
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module boot_mode_entry_control
	import boot_entry_pkg::*;
#(
	parameter int AW  = 15,
	parameter int APW = 8
)(
	// clock and reset
	input  wire logic           i_ref_clk,
	input  wire logic           i_reset_n,
	input  wire logic           i_wdt_reset,
	// mode pins
	input  wire logic           i_mode_pin_high,
	input  wire logic           i_mode_pin_low,
	input  wire logic           i_mode_pin_high_hv,
	input  wire logic           i_program_supply_pin_hv,
	// serial link
	input  wire logic           i_boot_serial_rx,
	output logic                o_boot_serial_tx,
	// flash array
	output logic                o_flash_rd,
	output logic     [AW-1:0]   o_flash_addr,
	input  wire logic [7:0]     i_flash_data,
	output logic                o_erase_all,
	input  wire logic           i_erase_done,
	input  wire logic           i_flash_access,
	input  wire logic           i_pe_active,
	// core side
	output logic                o_branch,
	output logic     [15:0]     o_branch_addr,
	output logic                o_irq_inhibit,
	output logic                o_flash_read_block,
	input  wire logic           i_standby_req,
	output logic                o_standby_enter,
	// serial unit and port 8 settings
	output logic                o_receiver_enable_bit,
	output logic                o_transmitter_enable_bit,
	output logic     [15:0]     o_baud_divisor_reg,
	output logic                o_port8_bit4_direction,
	output logic                o_port8_bit4_output,
	// pins during reset
	output logic     [APW-1:0]  o_addr_port_out,
	output logic                o_addr_port_oe,
	output logic                o_address_strobe_out,
	output logic                o_address_strobe_oe,
	// mode status
	output logic                o_boot_mode,
	output logic                o_user_prog_mode,
	output logic     [1:0]      o_mode_report,
	// register port
	input  wire logic [3:0]     i_addr,
	input  wire logic [31:0]    i_wdata,
	input  wire logic           i_wr,
	input  wire logic           i_rd,
	output logic     [31:0]     o_rdata
);

	if (AW < 1 || AW > 16 || APW < 1) begin : g_check
		$error("boot_mode_entry_control: unsupported width");
	end

	typedef enum logic [3:0] {
		S_RELEASE, S_NORMAL, S_MEASURE, S_SEND_ACK, S_WAIT_HOST,
		S_SCAN, S_ERASE, S_LOAD, S_HANDOFF, S_USER
	} boot_e;

	// ***********************************************
	// declarations
	// ***********************************************
	boot_e          state;
	boot_e          next_state;
	logic           next_boot_mode;
	logic [1:0]     next_mode_report;
	logic           next_user_prog;
	logic           re_bit;
	logic           next_re_bit;
	logic           te_bit;
	logic           next_te_bit;
	logic [15:0]    baud;
	logic [15:0]    next_baud;
	logic           p84_set;
	logic           next_p84_set;
	logic           aligned;
	logic           next_aligned;
	logic           erased;
	logic           next_erased;
	logic           handed;
	logic           next_handed;
	logic           next_branch;
	logic           next_erase_all;
	logic [AW-1:0]  scan_addr;
	logic [AW-1:0]  next_scan_addr;
	logic           scan_issued;
	logic           next_scan_issued;
	logic           rd_pend;
	logic           next_rd_pend;
	logic           dirty;
	logic           next_dirty;
	logic           rx_busy;
	logic           next_rx_busy;
	logic [15:0]    rx_cnt;
	logic [15:0]    next_rx_cnt;
	logic [3:0]     rx_idx;
	logic [3:0]     next_rx_idx;
	logic [7:0]     rx_sh;
	logic [7:0]     next_rx_sh;
	logic [31:0]    next_rdata;
	logic [1:0]     pin_mode;
	logic           meter_arm;
	logic           meter_done;
	logic [15:0]    meter_bits;
	logic           tx_start;
	logic           tx_busy;
	logic           tx_done;
	logic           wr_ctrl;
	logic           load_req;

	// ***********************************************
	// pins during reset and plain gating
	// ***********************************************
	assign pin_mode = {i_mode_pin_high | i_mode_pin_high_hv, i_mode_pin_low};
	assign o_addr_port_out      = '0;
	assign o_addr_port_oe       = !i_reset_n && (pin_mode == MODE1); // (R16)
	assign o_address_strobe_out = 1'b1;
	assign o_address_strobe_oe  = !i_reset_n && (pin_mode != MODE3); // (R16)
	assign o_standby_enter      = i_standby_req && !i_program_supply_pin_hv; // (R19)
	assign o_irq_inhibit        = (state == S_ERASE) || i_pe_active; // (R5)
	assign o_flash_read_block   = (state == S_ERASE) || i_pe_active; // (R20)
	assign o_flash_rd           = (state == S_SCAN) && !scan_issued;
	assign o_flash_addr         = scan_addr;
	assign o_branch_addr        = RAM_ENTRY;
	assign o_receiver_enable_bit    = re_bit;
	assign o_transmitter_enable_bit = te_bit;
	assign o_baud_divisor_reg       = baud;
	assign o_port8_bit4_direction   = p84_set; // (R7)
	assign o_port8_bit4_output      = p84_set; // (R7)
	assign meter_arm = (state == S_MEASURE);
	assign tx_start  = (state == S_MEASURE) && meter_done; // (R23)
	assign wr_ctrl   = i_wr && (i_addr == ADDR_CONTROL);
	assign load_req  = wr_ctrl && i_wdata[CT_LOAD_DONE];

	// ***********************************************
	// helpers
	// ***********************************************
	rate_meter u_meter (
		.i_ref_clk    (i_ref_clk),
		.i_reset_n    (i_reset_n),
		.i_arm        (meter_arm),
		.i_rx         (i_boot_serial_rx),
		.o_bit_cycles (meter_bits),
		.o_done       (meter_done)
	);

	serial_byte_tx u_tx (
		.i_ref_clk    (i_ref_clk),
		.i_reset_n    (i_reset_n),
		.i_start      (tx_start),
		.i_data       (ALIGN_ACK),
		.i_bit_cycles (meter_bits),
		.o_tx         (o_boot_serial_tx),
		.o_busy       (tx_busy),
		.o_done       (tx_done)
	);

	// ***********************************************
	// boot sequence
	// ***********************************************
	always_comb begin
		next_state       = state;
		next_boot_mode   = o_boot_mode;
		next_mode_report = o_mode_report;
		next_re_bit      = re_bit;
		next_te_bit      = te_bit;
		next_baud        = baud;
		next_p84_set     = p84_set;
		next_aligned     = aligned;
		next_erased      = erased;
		next_handed      = handed;
		next_branch      = 1'b0;
		next_erase_all   = 1'b0;
		next_scan_addr   = scan_addr;
		next_scan_issued = scan_issued;
		next_rd_pend     = 1'b0;
		next_dirty       = dirty;
		next_rx_busy     = rx_busy;
		next_rx_cnt      = rx_cnt;
		next_rx_idx      = rx_idx;
		next_rx_sh       = rx_sh;
		case (state)
			S_RELEASE: begin
				// only the first edge after the pin reset samples the straps
				next_boot_mode   = i_mode_pin_high_hv && i_program_supply_pin_hv; // (R10)
				next_mode_report = {1'b1, i_mode_pin_low}; // (R22)
				if (!i_mode_pin_high_hv) begin
					next_mode_report = pin_mode;
				end
				next_state = next_boot_mode ? S_MEASURE : S_NORMAL;
			end
			S_MEASURE: begin
				if (meter_done) begin
					next_baud    = meter_bits; // (R1)
					next_aligned = 1'b1;
					next_re_bit  = 1'b1;
					next_te_bit  = 1'b1;
					next_state   = S_SEND_ACK;
				end
			end
			S_SEND_ACK: begin
				next_rx_busy = 1'b0;
				if (tx_done && !tx_busy) begin
					next_state = S_WAIT_HOST; // (R23)
				end
			end
			S_WAIT_HOST: begin
				if (!rx_busy) begin
					if (!i_boot_serial_rx) begin
						next_rx_busy = 1'b1;
						next_rx_cnt  = {1'b0, baud[15:1]};
						next_rx_idx  = 4'h0;
					end
				end else if (rx_cnt != 16'h0000) begin
					next_rx_cnt = rx_cnt - 16'h0001;
				end else begin
					next_rx_cnt = bit_len_m1(baud);
					next_rx_idx = rx_idx + 4'h1;
					if (rx_idx == 4'h0) begin
						next_rx_busy = !i_boot_serial_rx;
					end else if (rx_idx != 4'h9) begin
						next_rx_sh = {i_boot_serial_rx, rx_sh[7:1]};
					end else begin
						next_rx_busy = 1'b0;
						if (i_boot_serial_rx && rx_sh == HOST_ACK) begin
							next_state       = S_SCAN; // (R23)
							next_scan_addr   = '0;
							next_scan_issued = 1'b0;
							next_dirty       = 1'b0;
						end
					end
				end
			end
			S_SCAN: begin
				if (!scan_issued) begin
					next_rd_pend = 1'b1;
					if (scan_addr == {AW{1'b1}}) begin
						next_scan_issued = 1'b1;
					end else begin
						next_scan_addr = scan_addr + 1'b1;
					end
				end
				if (rd_pend && i_flash_data != BLANK_BYTE) begin
					next_dirty = 1'b1; // (R4)
				end
				if (scan_issued && !rd_pend) begin
					next_erase_all = dirty; // (R4)
					next_state     = dirty ? S_ERASE : S_LOAD;
				end
			end
			S_ERASE: begin
				if (i_erase_done) begin
					next_erased = 1'b1; // (R4)
					next_state  = S_LOAD;
				end
			end
			S_LOAD: begin
				if (load_req) begin
					next_state = S_HANDOFF;
				end
			end
			S_HANDOFF: begin
				next_re_bit  = 1'b0; // (R6)
				next_te_bit  = 1'b0; // (R6)
				next_p84_set = 1'b1; // (R7)
				next_handed  = 1'b1;
				next_branch  = 1'b1; // (R9)
				next_state   = S_USER;
			end
			S_NORMAL, S_USER: begin
				next_state = state;
			end
			default: begin
				next_state = S_NORMAL;
			end
		endcase
		if (state == S_NORMAL || state == S_USER) begin
			if (wr_ctrl) begin
				next_re_bit = i_wdata[CT_RX_EN];
				next_te_bit = i_wdata[CT_TX_EN];
			end
			if (i_wr && i_addr == ADDR_BAUD) begin
				next_baud = i_wdata[15:0];
			end
		end
		if (i_wdt_reset && o_boot_mode && state != S_RELEASE) begin
			// boot state kept, serial and port settings back to reset values
			next_state   = S_MEASURE; // (R14)
			next_re_bit  = 1'b0;
			next_te_bit  = 1'b0;
			next_p84_set = 1'b0;
			next_aligned = 1'b0;
			next_erased  = 1'b0;
			next_handed  = 1'b0;
			next_baud    = BAUD_RESET;
		end
	end

	// boot state lives here until the pin reset; pin voltage is not re-read
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state         <= S_RELEASE;
			o_boot_mode   <= 1'b0; // (R15)
			o_mode_report <= 2'h0;
			re_bit        <= 1'b0;
			te_bit        <= 1'b0;
			baud          <= BAUD_RESET;
			p84_set       <= 1'b0;
			aligned       <= 1'b0;
			erased        <= 1'b0;
			handed        <= 1'b0;
			o_branch      <= 1'b0;
			o_erase_all   <= 1'b0;
			scan_addr     <= '0;
			scan_issued   <= 1'b0;
			rd_pend       <= 1'b0;
			dirty         <= 1'b0;
			rx_busy       <= 1'b0;
			rx_cnt        <= 16'h0000;
			rx_idx        <= 4'h0;
			rx_sh         <= 8'h00;
		end else begin
			state         <= next_state;
			o_boot_mode   <= next_boot_mode; // (R13)
			o_mode_report <= next_mode_report;
			re_bit        <= next_re_bit;
			te_bit        <= next_te_bit;
			baud          <= next_baud;
			p84_set       <= next_p84_set;
			aligned       <= next_aligned;
			erased        <= next_erased;
			handed        <= next_handed;
			o_branch      <= next_branch;
			o_erase_all   <= next_erase_all;
			scan_addr     <= next_scan_addr;
			scan_issued   <= next_scan_issued;
			rd_pend       <= next_rd_pend;
			dirty         <= next_dirty;
			rx_busy       <= next_rx_busy;
			rx_cnt        <= next_rx_cnt;
			rx_idx        <= next_rx_idx;
			rx_sh         <= next_rx_sh;
		end
	end

	// ***********************************************
	// user programming mode and register reads
	// ***********************************************
	always_comb begin
		next_user_prog = 1'b0;
		// only the flash side and the ST_USER status bit look at this flag
		if (!o_boot_mode && i_mode_pin_high && i_program_supply_pin_hv) begin
			next_user_prog = o_user_prog_mode || !i_flash_access; // (R17)
		end
		next_rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				ADDR_STATUS: begin
					next_rdata[ST_BOOT]     = o_boot_mode;
					next_rdata[ST_USER]     = o_user_prog_mode;
					next_rdata[ST_ALIGNED]  = aligned;
					next_rdata[ST_ERASED]   = erased;
					next_rdata[ST_HANDOFF]  = handed;
					next_rdata[ST_PE_BLOCK] = o_flash_read_block;
					next_rdata[ST_LOADING]  = (state == S_LOAD);
				end
				ADDR_CONTROL: begin
					next_rdata[CT_RX_EN] = re_bit;
					next_rdata[CT_TX_EN] = te_bit;
				end
				ADDR_BAUD: next_rdata[15:0] = baud;
				ADDR_MODE: next_rdata[1:0] = o_mode_report; // (R22)
				default:   next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_user_prog_mode <= 1'b0;
			o_rdata          <= 32'h0000_0000;
		end else begin
			o_user_prog_mode <= next_user_prog; // (R18)
			o_rdata          <= next_rdata;
		end
	end

endmodule

//--- tb/boot_host_model.sv
// host computer on the far side of the boot serial link
`timescale 1ns/10ps
module boot_host_model #(
	parameter int BIT = 20
)(
	// clock, reset and link
	input  logic i_ref_clk,
	input  logic i_reset_n,
	input  logic i_tx,
	output logic o_rx
);
	logic [8:0] got;

	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			o_rx <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : b[i-1];
			repeat (BIT) @(posedge i_ref_clk);
		end
	endtask

	initial begin
		o_rx = 1'h1;
		forever begin
			@(posedge i_reset_n);
			repeat (120) @(posedge i_ref_clk);
			fork send(8'h00); join_none
			@(negedge i_tx);
			repeat (BIT * 3 / 2) @(posedge i_ref_clk);
			for (int i = 0; i < 9; i++) begin
				got[i] = i_tx;
				repeat (BIT) @(posedge i_ref_clk);
			end
			if (got === 9'h100) send(8'h55);
		end
	end
endmodule

//--- tb/boot_entry_asserts.sv
// concurrent checks on the boot mode entry ports
`timescale 1ns/10ps
module boot_entry_asserts (
	// clock, reset and pins
	input logic i_ref_clk, i_reset_n, i_wdt_reset, i_mode_pin_high, i_mode_pin_low,
	input logic i_mode_pin_high_hv, i_program_supply_pin_hv, i_pe_active, i_standby_req,
	// outputs watched
	input logic o_boot_serial_tx, o_branch, o_receiver_enable_bit, o_transmitter_enable_bit,
	input logic o_port8_bit4_direction, o_port8_bit4_output, o_addr_port_oe,
	input logic o_address_strobe_oe, o_boot_mode, o_irq_inhibit, o_flash_read_block,
	input logic o_standby_enter,
	input logic [15:0] o_baud_divisor_reg,
	input logic [1:0] o_mode_report
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	property p_handoff;
		o_branch |-> !o_receiver_enable_bit && !o_transmitter_enable_bit && o_boot_serial_tx
			&& o_port8_bit4_direction && o_port8_bit4_output
			&& o_baud_divisor_reg == $past(o_baud_divisor_reg);
	endproperty
	a_handoff: assert property (p_handoff) else $error("hand-off state wrong");
	property p_entry;
		$rose(i_reset_n) |=> o_boot_mode == $past(i_mode_pin_high_hv && i_program_supply_pin_hv);
	endproperty
	a_entry: assert property (p_entry) else $error("boot strap not latched");
	property p_hold;
		o_boot_mode |=> o_boot_mode;
	endproperty
	a_hold: assert property (p_hold) else $error("boot state lost");
	property p_wdt;
		o_boot_mode && i_wdt_reset |=> o_boot_mode && !o_receiver_enable_bit
			&& !o_port8_bit4_direction && o_baud_divisor_reg == 16'h0000;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog restart wrong");
	property p_irq;
		i_pe_active |-> o_irq_inhibit && o_flash_read_block;
	endproperty
	a_irq: assert property (p_irq) else $error("irq or read not blocked");
	property p_standby;
		o_standby_enter == (i_standby_req && !i_program_supply_pin_hv);
	endproperty
	a_standby: assert property (p_standby) else $error("standby with supply high");
	property p_mode_rep;
		o_boot_mode |-> o_mode_report == {1'h1, i_mode_pin_low};
	endproperty
	a_mode_rep: assert property (p_mode_rep) else $error("mode report wrong");
	property p_addr_oe;
		disable iff (i_reset_n) o_addr_port_oe == ({i_mode_pin_high, i_mode_pin_low} == 2'h1);
	endproperty
	a_addr_oe: assert property (p_addr_oe) else $error("address port drive wrong");
	property p_strobe_oe;
		disable iff (i_reset_n) o_address_strobe_oe == ({i_mode_pin_high, i_mode_pin_low} != 2'h3);
	endproperty
	a_strobe_oe: assert property (p_strobe_oe) else $error("strobe drive wrong");
endmodule

bind boot_mode_entry_control boot_entry_asserts boot_entry_asserts_inst (.*);

//--- tb/test_boot_mode_entry_control.sv
// self-checking bench for the boot mode entry logic
`timescale 1ns/10ps
module test_boot_mode_entry_control;
	import boot_entry_pkg::*;
	localparam int BIT = 20;
	logic i_ref_clk = 0, i_reset_n = 0, i_wdt_reset = 0, i_erase_done = 0, i_wr = 0, i_rd = 0;
	logic i_mode_pin_high = 0, i_mode_pin_low = 1, i_mode_pin_high_hv = 0, i_pe_active = 0;
	logic i_program_supply_pin_hv = 0, i_flash_access = 0, i_standby_req = 0;
	logic [3:0] i_addr = 4'h0, o_flash_addr;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [7:0] i_flash_data = 8'hFF, o_addr_port_out;
	logic [15:0] o_branch_addr, o_baud_divisor_reg;
	logic [1:0] o_mode_report;
	logic [2:0] ers = 3'h0;
	logic i_boot_serial_rx, o_boot_serial_tx, o_flash_rd, o_erase_all, o_branch, o_irq_inhibit;
	logic o_flash_read_block, o_standby_enter, o_receiver_enable_bit, o_transmitter_enable_bit;
	logic o_port8_bit4_direction, o_port8_bit4_output, o_addr_port_oe, o_address_strobe_out;
	logic o_address_strobe_oe, o_boot_mode, o_user_prog_mode;
	int fail_count = 0, compares = 0;

	boot_mode_entry_control #(.AW(4)) boot_mode_entry_control_inst (.*);
	boot_host_model #(.BIT(BIT)) boot_host_model_inst (.i_ref_clk, .i_reset_n,
		.i_tx(o_boot_serial_tx), .o_rx(i_boot_serial_rx));

	always #50 i_ref_clk = ~i_ref_clk;
	// flash with one programmed byte, erase answered four cycles on
	always @(posedge i_ref_clk) i_flash_data <= (o_flash_rd && o_flash_addr == 4'h9) ? 8'h3C : 8'hFF;
	always @(posedge i_ref_clk) {i_erase_done, ers} <= {ers, o_erase_all};

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e, input string n);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_ref_clk);
		i_rd <= 1'h0;
		@(negedge i_ref_clk);
		chk(n, e, o_rdata);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_ref_clk);
		i_wr <= 1'h0;
	endtask
	task end_of_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ***********************************************
	// scenarios
	// ***********************************************
	task t_pins;
		for (int m = 1; m < 4; m++) begin
			@(posedge i_ref_clk);
			{i_mode_pin_high, i_mode_pin_low} <= m[1:0];
			@(negedge i_ref_clk);
			chk("addr_oe", m == 1, o_addr_port_oe);
			chk("strobe_oe", m != 3, o_address_strobe_oe);
			chk("strobe", 1'h1, o_address_strobe_out);
			chk("addr_port", 8'h00, o_addr_port_out);
		end
		$display("t_pins done");
	endtask
	task automatic t_boot;
		int n;
		@(posedge i_ref_clk);
		{i_mode_pin_high, i_mode_pin_low} <= 2'h2;
		i_mode_pin_high_hv <= 1'h1;
		i_program_supply_pin_hv <= 1'h1;
		@(posedge i_ref_clk);
		i_reset_n <= 1'h1;
		repeat (3) @(posedge i_ref_clk);
		i_mode_pin_high_hv <= 1'h0;
		for (n = 0; n < 3000 && o_erase_all !== 1'h1; n++) @(negedge i_ref_clk);
		chk("erase_all", 1'h1, o_erase_all);
		chk("baud", BIT, o_baud_divisor_reg);
		repeat (2) @(negedge i_ref_clk);
		chk("irq_inhibit", 1'h1, o_irq_inhibit);
		repeat (10) @(negedge i_ref_clk);
		chk("rx_en", 1'h1, o_receiver_enable_bit);
		rdc(ADDR_STATUS, 32'h4D, "status");
		rdc(ADDR_MODE, 32'h2, "mode");
		wr(ADDR_CONTROL, 32'h1);
		for (n = 0; n < 5 && o_branch !== 1'h1; n++) @(negedge i_ref_clk);
		chk("branch", 1'h1, o_branch);
		chk("branch_addr", RAM_ENTRY, o_branch_addr);
		chk("en", 2'h0, {o_receiver_enable_bit, o_transmitter_enable_bit});
		chk("baud", BIT, o_baud_divisor_reg);
		chk("p84", 3'h7, {o_port8_bit4_direction, o_port8_bit4_output, o_boot_serial_tx});
		$display("t_boot done");
	endtask
	task t_wdt;
		@(posedge i_ref_clk);
		i_wdt_reset <= 1'h1;
		@(posedge i_ref_clk);
		i_wdt_reset <= 1'h0;
		@(negedge i_ref_clk);
		chk("boot_mode", 1'h1, o_boot_mode);
		chk("baud", 16'h0000, o_baud_divisor_reg);
		chk("p84_dir", 1'h0, o_port8_bit4_direction);
		$display("t_wdt done");
	endtask
	task t_exit;
		@(posedge i_ref_clk);
		i_reset_n <= 1'h0;
		repeat (10) @(posedge i_ref_clk);
		i_program_supply_pin_hv <= 1'h0;
		{i_mode_pin_high, i_mode_pin_low} <= 2'h3;
		@(posedge i_ref_clk);
		i_reset_n <= 1'h1;
		repeat (3) @(posedge i_ref_clk);
		i_program_supply_pin_hv <= 1'h1;
		i_standby_req <= 1'h1;
		repeat (3) @(negedge i_ref_clk);
		chk("boot_mode", 1'h0, o_boot_mode);
		chk("user_mode", 1'h1, o_user_prog_mode);
		chk("standby", 1'h0, o_standby_enter);
		@(posedge i_ref_clk);
		i_program_supply_pin_hv <= 1'h0;
		i_pe_active <= 1'h1;
		repeat (2) @(negedge i_ref_clk);
		chk("user_mode", 1'h0, o_user_prog_mode);
		chk("standby", 1'h1, o_standby_enter);
		chk("read_block", 1'h1, o_flash_read_block);
		rdc(4'h2, 32'h0, "unmapped");
		$display("t_exit done");
	endtask

	initial begin
		t_pins;
		t_boot;
		t_wdt;
		t_exit;
		end_of_test;
	end
	// run needs about 800 cycles
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		fail_count++;
		end_of_test;
	end
endmodule
